// ==== design/isds_top.sv ====
`timescale 1ns/1ps
`include "isds_consts.svh"
//
// Contract
// - Each of eight microframes gets a 3-bit result; uframe 0 at bits 10:8.
// - Result bit 0 reports transaction error, IN and OUT.
// - Result bit 1 reports babble, IN only.
// - Result bit 2 reports underrun, OUT only.
// - Software sets start-split mask bits; device clears each after its microframe.
// - OUT: when frame matches, test mask bit before sending in that microframe.
// - Active flag bit 63 mirrors valid; device clears it when finished.
// - Halt bit 62 set when any microframe stalls or halts.
// - Summary babble bit 61 reflects result bit 1 of all microframes.
// - Summary error bit 60 reflects result bit 0 of all microframes.
// - Software seeds toggle bit 57; device may rewrite it.
// - Device writes moved byte count into bits 43:32.
// - Complete-split mask selects IN complete-split microframes; device clears each once its split reports done.
// - Device clears valid bit 0 when done or on fatal error.
// - Frame field bits 7:3 select the frame to execute.
// - Received bytes stored per microframe only if mask set and frame matches.
module isds_top #(
  parameter int unsigned UFRAMES = 8
) (
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_NRST,
  // axi4-lite write
  input  wire logic [11:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // axi4-lite read
  input  wire logic [11:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // link engine: microframe slot strobe and outcome
  input  wire logic [4:0]  I_BUS_FRAME,
  input  wire logic [2:0]  I_UFRAME,
  input  wire logic        I_UFRAME_END,
  input  wire logic        I_XERR,
  input  wire logic        I_BABBLE,
  input  wire logic        I_UNDERRUN,
  input  wire logic        I_STALL,
  input  wire logic        I_FATAL,
  input  wire logic        I_CS_DONE,
  input  wire logic        I_TOGGLE_NEW,
  input  wire logic [7:0]  I_RX_BYTES,
  // link engine requests
  output logic             O_SEND_SS,
  output logic             O_SEND_CS,
  // interrupt
  output logic             O_IRQ
);
  initial begin
    if (UFRAMES != 8) $error("isds_top serves exactly eight microframes");
  end

  typedef struct packed {
    logic [31:0] dw0, dw2, dw3hi, dw4, dw5lo, dw6, dw7;
    logic [2:0]  irq_stat, irq_mask;
    logic        aw_got, w_got, bvalid, rvalid;
    logic [11:0] awaddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    isds_pkg::isds_phase_t phase;
  } isds_state_t;

  isds_state_t st, next_st;
  logic [2:0]  res;
  logic        is_in, frame_hit, ss_hit, cs_hit, slot_go;

  // dw3hi holds the status half; dw5lo holds the cs mask and the first received bytes
  function automatic logic [31:0] isds_strb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] s);
    for (int i = 0; i < 4; i++) isds_strb[i*8 +: 8] = s[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  isds_uframe_exec u_exec (
    .i_is_in  (is_in),
    .i_xerr   (I_XERR),
    .i_babble (I_BABBLE),
    .i_under  (I_UNDERRUN),
    .o_result (res)
  );

  //////////////////////////////////////////////////////////////////////////
  // slot decode
  always_comb begin
    is_in = st.dw2[`ISDS_POS_TOKEN - 32];
    frame_hit = st.dw2[7:3] == I_BUS_FRAME;
    ss_hit  = frame_hit & st.dw4[I_UFRAME] & st.dw3hi[`ISDS_POS_ACTIVE - 32];
    // complete splits also wait for the selected frame
    cs_hit  = frame_hit & is_in & st.dw5lo[I_UFRAME] & st.dw3hi[`ISDS_POS_ACTIVE - 32];
    slot_go = I_UFRAME_END & (ss_hit | cs_hit);
    O_SEND_SS = ss_hit;
    O_SEND_CS = cs_hit & (st.phase == isds_pkg::ISDS_CS);
  end

  //////////////////////////////////////////////////////////////////////////
  // next state: bus slave plus descriptor write-back
  always_comb begin
    logic [2:0] ev;
    ev = 3'h0;
    next_st = st;
    // write channel, either order
    if (I_AWVALID && !st.aw_got) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = I_AWADDR;
    end
    if (I_WVALID && !st.w_got) begin
      next_st.w_got = 1'b1;
      next_st.wdata = I_WDATA;
      next_st.wstrb = I_WSTRB;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = 2'b00;
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      if (st.awaddr == `ISDS_OFF_DW0) begin
        next_st.dw0 = isds_strb(st.dw0, st.wdata, st.wstrb);
      end else if (st.awaddr == `ISDS_OFF_DW2) begin
        next_st.dw2 = isds_strb(st.dw2, st.wdata, st.wstrb);
      end else if (st.awaddr == `ISDS_OFF_DW3) begin
        next_st.dw4 = {st.dw4[31:8], st.dw4[7:0] | st.wdata[7:0]};
      end else if (st.awaddr == `ISDS_OFF_DW4) begin
        next_st.dw3hi = st.wdata;
      end else if (st.awaddr == `ISDS_OFF_DW5) begin
        next_st.dw5lo = st.dw5lo | {24'h0, st.wdata[7:0]};
      end else if (st.awaddr == `ISDS_OFF_IRQ_STAT) begin
        next_st.irq_stat = st.irq_stat & ~st.wdata[2:0];
      end else if (st.awaddr == `ISDS_OFF_IRQ_MASK) begin
        next_st.irq_mask = st.wdata[2:0];
      end else begin
        next_st.bresp = 2'b10;
      end
    end
    if (st.bvalid && I_BREADY) next_st.bvalid = 1'b0;
    // read channel
    if (I_ARVALID && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = 2'b00;
      if (I_ARADDR == `ISDS_OFF_DW0) next_st.rdata = st.dw0;
      else if (I_ARADDR == `ISDS_OFF_DW2) next_st.rdata = st.dw2;
      else if (I_ARADDR == `ISDS_OFF_DW3) next_st.rdata = st.dw4;
      else if (I_ARADDR == `ISDS_OFF_DW4) next_st.rdata = st.dw3hi;
      else if (I_ARADDR == `ISDS_OFF_DW5) next_st.rdata = st.dw5lo;
      else if (I_ARADDR == `ISDS_OFF_DW6) next_st.rdata = st.dw6;
      else if (I_ARADDR == `ISDS_OFF_DW7) next_st.rdata = st.dw7;
      else if (I_ARADDR == `ISDS_OFF_FRNUM) next_st.rdata = {27'h0, I_BUS_FRAME};
      else if (I_ARADDR == `ISDS_OFF_IRQ_STAT) next_st.rdata = {29'h0, st.irq_stat};
      else if (I_ARADDR == `ISDS_OFF_IRQ_MASK) next_st.rdata = {29'h0, st.irq_mask};
      else begin
        next_st.rdata = 32'h0;
        next_st.rresp = 2'b10;
      end
    end
    if (st.rvalid && I_RREADY) next_st.rvalid = 1'b0;
    if (next_st.dw0[`ISDS_POS_VALID] && !st.dw0[`ISDS_POS_VALID]) begin
      next_st.dw3hi[`ISDS_POS_ACTIVE - 32] = 1'b1;
      next_st.dw3hi[`ISDS_POS_PHASE - 32] = 1'b0;
      next_st.dw3hi[11:0] = 12'h000;
      next_st.phase = isds_pkg::ISDS_SS;
    end
    // microframe write-back, wins over software edits in the same cycle
    if (slot_go) begin
      next_st.dw4[`ISDS_POS_RES_LO + 3*I_UFRAME +: 3] = res;
      if (res[`ISDS_RES_XERR]) next_st.dw3hi[`ISDS_POS_XERR - 32] = 1'b1;
      if (res[`ISDS_RES_BABBLE]) next_st.dw3hi[`ISDS_POS_BABBLE - 32] = 1'b1;
      if (I_STALL) next_st.dw3hi[`ISDS_POS_HALT - 32] = 1'b1;
      next_st.dw3hi[`ISDS_POS_TOGGLE - 32] = I_TOGGLE_NEW;
      // byte count summed over the descriptor's microframes
      next_st.dw3hi[11:0] = st.dw3hi[11:0] + {4'h0, I_RX_BYTES};
      // received bytes only when mask and frame hit
      if (ss_hit) begin
        if (I_UFRAME < 3'h3) next_st.dw5lo[8 + 8*I_UFRAME +: 8] = I_RX_BYTES;
        else if (I_UFRAME < 3'h7) next_st.dw6[8*(I_UFRAME - 3'h3) +: 8] = I_RX_BYTES;
        else next_st.dw7[7:0] = I_RX_BYTES;
        next_st.dw4[I_UFRAME] = 1'b0;
        if (is_in) begin
          next_st.dw3hi[`ISDS_POS_PHASE - 32] = 1'b1;
          next_st.phase = isds_pkg::ISDS_CS;
        end
      end
      if (cs_hit && I_CS_DONE) next_st.dw5lo[I_UFRAME] = 1'b0;
      if (res != 3'h0 || I_STALL) ev[`ISDS_IRQ_ERR] = 1'b1;
      if (I_STALL) ev[`ISDS_IRQ_HALT] = 1'b1;
    end
    // retire on completion or fatal error
    if (st.dw3hi[`ISDS_POS_ACTIVE - 32] &&
        (I_FATAL || (slot_go && next_st.dw4[7:0] == 8'h0 && next_st.dw5lo[7:0] == 8'h0))) begin
      next_st.dw0[`ISDS_POS_VALID] = 1'b0;
      next_st.dw3hi[`ISDS_POS_ACTIVE - 32] = 1'b0;
      next_st.phase = isds_pkg::ISDS_DONE;
      ev[`ISDS_IRQ_DONE] = 1'b1;
    end
    // event sets beat a simultaneous clear
    next_st.irq_stat = next_st.irq_stat | ev;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // bus outputs
  always_comb begin
    O_AWREADY = !st.aw_got;
    O_WREADY  = !st.w_got;
    O_BVALID  = st.bvalid;
    O_BRESP   = st.bresp;
    O_ARREADY = !st.rvalid;
    O_RVALID  = st.rvalid;
    O_RDATA   = st.rdata;
    O_RRESP   = st.rresp;
    O_IRQ     = |(st.irq_stat & st.irq_mask);
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  // result lands in slot
  result_slot_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    slot_go |=> st.dw4[8 + 3*$past(I_UFRAME) +: 3] == $past(res)) else $error("result slot wrong");
  babble_in_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    !is_in |-> !res[1]) else $error("babble on OUT");
  under_out_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    is_in |-> !res[2]) else $error("underrun on IN");
  ss_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (slot_go && ss_hit) |=> !st.dw4[$past(I_UFRAME)]) else $error("ss slot kept");
  send_frame_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    O_SEND_SS |-> st.dw2[7:3] == I_BUS_FRAME) else $error("send off frame");
  halt_set_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (slot_go && I_STALL) |=> st.dw3hi[30]) else $error("halt missing");
  xerr_sum_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (slot_go && I_XERR) |=> st.dw3hi[28]) else $error("xerr summary missing");
  fatal_done_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
    (I_FATAL && st.dw3hi[31]) |=> !st.dw0[0] && !st.dw3hi[31]) else $error("fatal not retired");
endmodule

// ==== include/isds_consts.svh ====
`ifndef ISDS_CONSTS_SVH
`define ISDS_CONSTS_SVH
// register byte offsets
`define ISDS_OFF_DW0      12'h000
`define ISDS_OFF_DW2      12'h008
`define ISDS_OFF_DW3      12'h00C
`define ISDS_OFF_DW4      12'h010
`define ISDS_OFF_DW5      12'h014
`define ISDS_OFF_DW6      12'h018
`define ISDS_OFF_DW7      12'h01C
`define ISDS_OFF_FRNUM    12'h040
`define ISDS_OFF_IRQ_STAT 12'h044
`define ISDS_OFF_IRQ_MASK 12'h048
// field positions in 64-bit words
`define ISDS_POS_VALID    0
`define ISDS_POS_ACTIVE   63
`define ISDS_POS_HALT     62
`define ISDS_POS_BABBLE   61
`define ISDS_POS_XERR     60
`define ISDS_POS_PHASE    59
`define ISDS_POS_TOGGLE   57
`define ISDS_POS_CNT_LO   32
`define ISDS_POS_RES_LO   8
`define ISDS_POS_FRM_LO   3
`define ISDS_POS_TOKEN    42
// result field bits
`define ISDS_RES_XERR     0
`define ISDS_RES_BABBLE   1
`define ISDS_RES_UNDER    2
// interrupt status bits
`define ISDS_IRQ_DONE     0
`define ISDS_IRQ_ERR      1
`define ISDS_IRQ_HALT     2
// reset values
`define ISDS_RST_WORD     32'h0000_0000
`define ISDS_RST_MASK     3'h0
`endif

// ==== include/isds_pkg.sv ====
package isds_pkg;
  typedef enum logic [1:0] {ISDS_SS, ISDS_CS, ISDS_DONE} isds_phase_t;
  typedef enum logic [1:0] {ISDS_W_ADDR, ISDS_W_RESP} isds_wr_st_t;
endpackage

// ==== design/isds_uframe_exec.sv ====
`timescale 1ns/1ps
`include "isds_consts.svh"
// one microframe outcome: builds the 3-bit result field
module isds_uframe_exec (
  // outcome from link
  input  wire logic       i_is_in,
  input  wire logic       i_xerr,
  input  wire logic       i_babble,
  input  wire logic       i_under,
  // encoded result
  output logic [2:0]      o_result
);
  // babble only means something on IN, underrun only on OUT
  always_comb begin
    o_result = 3'h0;
    o_result[`ISDS_RES_XERR] = i_xerr;
    o_result[`ISDS_RES_BABBLE] = i_is_in & i_babble;
    o_result[`ISDS_RES_UNDER] = ~i_is_in & i_under;
  end
endmodule

// ==== testbench/isds_link_model.sv ====
`timescale 1ns/1ps
// stand-in for the link engine and hub: eight microframes of eight cycles per run
module isds_link_model (
  // clock and control
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_run,
  input  wire logic [7:0] i_cfg [6],
  input  wire logic       i_send_ss,
  input  wire logic       i_send_cs,
  // microframe outcome
  output logic [2:0]      o_uframe,
  output logic            o_end,
  output logic [5:0]      o_flag,
  output logic [7:0]      o_rx_bytes,
  output logic [7:0]      o_ss_seen,
  output logic [7:0]      o_cs_seen
);
  logic [2:0] cyc;
  logic [3:0] uf;
  // outcome lines only hold meaning at the commit pulse; flags inverted and byte count replaced elsewhere to expose early sampling
  always_comb begin
    o_uframe = uf[2:0];
    o_end = !uf[3] && cyc == 3'h7;
    for (int k = 0; k < 6; k++) o_flag[k] = i_cfg[k][uf[2:0]] ^ !o_end;
    o_rx_bytes = o_end ? 8'h20 + uf[2:0] : {5'h15, cyc};
  end
  // steps the microframes and notes where a start split was requested
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      uf <= 4'h8;
      cyc <= 3'h0;
      o_ss_seen <= 8'h00;
      o_cs_seen <= 8'h00;
    end else if (uf[3]) begin
      if (i_run) uf <= 4'h0;
      if (i_run) o_ss_seen <= 8'h00;
      if (i_run) o_cs_seen <= 8'h00;
    end else begin
      cyc <= cyc + 3'h1;
      if (i_send_ss) o_ss_seen[uf[2:0]] <= 1'b1;
      if (i_send_cs) o_cs_seen[uf[2:0]] <= 1'b1;
      if (cyc == 3'h7) uf <= uf + 4'h1;
    end
  end
endmodule

// ==== testbench/tb_isds_top.sv ====
`timescale 1ns/1ps
`include "isds_consts.svh"
module tb_isds_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, run = 1'b0, fatal = 1'b0;
  logic [4:0]  bus_frame = 5'h00;
  logic [7:0]  cfg [6] = '{default: 8'h00};
  wire         awready, wready, bvalid, arready, rvalid, send_ss, send_cs, irq, uend;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [2:0]   uframe;
  wire [5:0]   flag;
  wire [7:0]   rx, ss_seen, cs_seen;
  int          n_errors = 0;
  int          checks_done = 0;
  logic [31:0] d;
  logic [1:0]  r;

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  isds_top u_isds_top (
    .I_CLK_SYS(clk), .I_NRST(nrst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_BUS_FRAME(bus_frame),
    .I_UFRAME(uframe), .I_UFRAME_END(uend), .I_XERR(flag[0]), .I_BABBLE(flag[1]), .I_UNDERRUN(flag[2]),
    .I_STALL(flag[3]), .I_FATAL(fatal), .I_CS_DONE(flag[5]), .I_TOGGLE_NEW(flag[4]), .I_RX_BYTES(rx),
    .O_SEND_SS(send_ss), .O_SEND_CS(send_cs), .O_IRQ(irq));
  isds_link_model u_isds_link_model (.i_clk(clk), .i_nrst(nrst), .i_run(run), .i_cfg(cfg),
    .i_send_ss(send_ss), .i_send_cs(send_cs), .o_uframe(uframe), .o_end(uend), .o_flag(flag),
    .o_rx_bytes(rx), .o_ss_seen(ss_seen), .o_cs_seen(cs_seen));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clk);
    {awaddr, wdata} <= {a, v};
    {awvalid, wvalid, bready} <= 3'b111;
    for (int t = 0; t < 100 && !b; t++) begin
      @(negedge clk);
      {aw, w, b, r} = {awvalid && awready, wvalid && wready, bvalid, bresp};
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    chk("write answer", b, 1);
  endtask
  // read: data taken at the edge where rvalid is seen
  task automatic axr(input logic [11:0] a);
    logic ar, v;
    v = 1'b0;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (int t = 0; t < 100 && !v; t++) begin
      @(negedge clk);
      {ar, v, d, r} = {arvalid && arready, rvalid, rdata, rresp};
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (v) rready <= 1'b0;
    end
    chk("read answer", v, 1);
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a);
    chk(what, d & m, e);
  endtask
  // second resets in mid-run keep descriptors independent
  task automatic rst(input int n);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (n) @(posedge clk);
    nrst <= 1'b1;
  endtask
  // one pass of eight microframes; the model fixes its length at 64 cycles
  task automatic go(input logic [4:0] f);
    @(posedge clk);
    {bus_frame, run} <= {f, 1'b1};
    @(posedge clk);
    run <= 1'b0;
    repeat (70) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic        is_in, tog;
    logic [4:0]  frm;
    logic [7:0]  ss, cs, hit;
    logic [23:0] res;
    logic [11:0] cnt;
    logic [2:0]  sum;
    logic [63:0] rxw;
    void'($urandom(87494));
    rst(8);
    rchk("results rst", `ISDS_OFF_DW3, 32'hFFFF_FFFF, `ISDS_RST_WORD);
    rchk("status rst", `ISDS_OFF_DW4, 32'hFFFF_FFFF, `ISDS_RST_WORD);
    rchk("irq rst", `ISDS_OFF_IRQ_STAT, 32'hFFFF_FFFF, `ISDS_RST_WORD);
    axr(12'h100);
    chk("read refused", {d[29:0], r}, 32'h0000_0002);
    axw(12'h104, 32'h0000_0001);
    chk("write refused", r, 2);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      rst(2);
      is_in = i[0];
      tog = 1'($urandom);
      frm = 5'($urandom);
      ss = (i == 0) ? 8'hFF : 8'($urandom) | 8'h01;
      cs = 8'($urandom) & 8'hF0 | 8'h10;
      foreach (cfg[k]) cfg[k] <= (k == 5) ? 8'hFF : 8'($urandom);
      // IN start splits in microframes 0 to 3 only
      if (is_in) ss = ss & 8'h0F;
      hit = is_in ? ss | cs : ss;
      axw(`ISDS_OFF_DW2, {21'h0, is_in, 2'h0, frm, 3'h0});
      axw(`ISDS_OFF_DW3, {24'h0, ss});
      if (is_in) axw(`ISDS_OFF_DW5, {24'h0, cs});
      // active as valid, toggle seed, phase start
      axw(`ISDS_OFF_DW4, {1'b1, 5'h0, tog, 25'h0});
      axw(`ISDS_OFF_DW0, 32'h0000_0001);
      axw(`ISDS_OFF_IRQ_MASK, {31'h0, i != 1});
      rchk("seed", `ISDS_OFF_DW4, 32'hFA00_0000, {1'b1, 5'h0, tog, 25'h0});
      if (i < 2) begin
        go(frm ^ 5'h01);
        chk("ss off frame", ss_seen, 0);
        chk("cs off frame", cs_seen, 0);
        rchk("slots kept", `ISDS_OFF_DW3, 32'hFFFF_FFFF, {24'h0, ss});
      end
      go(frm);
      chk("ss slots", ss_seen, ss);
      chk("cs slots", cs_seen, is_in ? cs : 8'h00);
      {res, cnt, sum, rxw} = '0;
      for (int u = 0; u < 8; u++) begin
        if (hit[u]) begin
          tog = cfg[4][u];
          if (ss[u]) rxw[8*u +: 8] = 8'h20 + 8'(u);
          res[3*u +: 3] = {!is_in & cfg[2][u], is_in & cfg[1][u], cfg[0][u]};
          sum = sum | {cfg[3][u], res[3*u+1], res[3*u]};
          cnt = cnt + 12'h020 + 12'(u);
        end
      end
      rchk("results", `ISDS_OFF_DW3, 32'hFFFF_FFFF, {res, 8'h00});
      rchk("rx low", `ISDS_OFF_DW5, 32'hFFFF_FFFF, {rxw[23:0], 8'h00});
      rchk("rx mid", `ISDS_OFF_DW6, 32'hFFFF_FFFF, rxw[55:24]);
      rchk("rx high", `ISDS_OFF_DW7, 32'hFFFF_FFFF, {24'h0, rxw[63:56]});
      rchk("summary", `ISDS_OFF_DW4, 32'hFA00_0FFF, {1'b0, sum, is_in, 1'b0, tog, 13'h0, cnt});
      rchk("valid", `ISDS_OFF_DW0, 32'h0000_0001, 0);
      rchk("irq done", `ISDS_OFF_IRQ_STAT, 32'h0000_0001, 1);
      chk("irq line", irq, i != 1);
      axw(`ISDS_OFF_IRQ_STAT, 32'h0000_0007);
      chk("irq cleared", irq, 0);
      $display("test descriptor %0d done", i);
    end
    rst(2);
    axw(`ISDS_OFF_DW3, 32'h0000_0001);
    axw(`ISDS_OFF_DW0, 32'h0000_0001);
    @(posedge clk) fatal <= 1'b1;
    @(posedge clk) fatal <= 1'b0;
    rchk("fatal stop", `ISDS_OFF_DW0, 32'h0000_0001, 0);
    $display("test fatal done");
    test_done();
  end
  // hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    #500000;
    n_errors++;
    test_done();
  end
endmodule
